// File: rtl/status_irq_pkg.sv
// constants, field layouts and line carriers for the card status-change interrupt block
//
// Operation
// - a flag whose source is masked off always reads zero.
// - an unmasked source sets its flag, held until software clears it.
// - any set unmasked flag requests an interrupt on the selected route.
// - flags clear on status read or on write of one, picked by clear mode.
// - status bits 7 to 4 always read zero.
// - bit 3 sets when either card detect line changes.
// - memory card: bit 2 sets only on a rising ready edge.
// - I/O card: bits 2 and 1 always read zero.
// - memory card: bit 1 sets on a battery warning condition.
// - memory card: bit 0 sets while the status-change line is asserted.
// - ring indicate enabled: bit 0 shows the ring line state.
// - select field: 0 none, 1 IRQ1, 2 management interrupt, 3 to 15 that IRQ.
// - select zero with diagnostic route set sends status interrupts to PCI.
// - select zero, diagnostic route clear: PCI only when the PCI route bit is set.
// - config bit 3 gates card detect change flag and interrupt.
// - config bit 2 gates the ready rising edge interrupt.
// - config bit 1 gates the battery warning interrupt.
// - config bit 0 gates battery dead or I/O status-change interrupt.
// - status register reads 00h after reset.
// - PCI route bit set sends status interrupts to PCI, else select field routes.
// - card kind 0 is a memory card, 1 an I/O card.
// - ring indicate enable turns bit 0 into ring indicate; off after reset.
`default_nettype none

package status_irq_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int SOCKETS = 2;
    localparam logic [7:0] SOCKET_A_BASE = 8'h00;
    localparam logic [7:0] SOCKET_B_BASE = 8'h40;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CONFIG_OFFSET = 8'h05;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FLAG_DEAD = 0;
    localparam int FLAG_WARN = 1;
    localparam int FLAG_READY = 2;
    localparam int FLAG_DETECT = 3;
    localparam int SELECT_LSB = 4;
    localparam logic [3:0] SELECT_NONE = 4'h0;
    localparam logic [3:0] SELECT_MGMT = 4'h2;
    localparam logic [3:0] IO_CARD_FLAG_MASK = 4'h9;
    localparam logic [3:0] MEM_CARD_FLAG_MASK = 4'hF;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic card_detect_a_n;
        logic card_detect_b_n;
        logic ready;
        logic battery_warn;
        logic card_status_line;
    } card_lines_t;

    typedef struct packed {
        logic card_kind;
        logic ring_indicate_enable;
        logic status_to_pci_route;
    } socket_ctl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } reg_req_t;

    localparam card_lines_t LINES_RESET = '0;

endpackage : status_irq_pkg

`default_nettype wire

// File: rtl/input_sync3.sv
// three-stage synchroniser with agreement filter for card pins
`default_nettype none

module input_sync3 #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // lines
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    // a bit moves only once stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            out_next[i] = (stage2_reg[i] == stage3_reg[i]) ? stage3_reg[i] : out_reg[i];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            out_reg <= '0;
        end else begin
            stage1_reg <= din;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;

endmodule : input_sync3

`default_nettype wire

// File: rtl/status_change_irq.sv
// two-socket card status-change flags, masks, register port and interrupt routing
`default_nettype none

module status_change_irq (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire status_irq_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // card pins, one set per socket
    input wire status_irq_pkg::card_lines_t [1:0] card_lines,
    // control bits held outside this block
    input wire status_irq_pkg::socket_ctl_t [1:0] socket_ctl,
    input wire logic clear_mode_w1c,
    input wire logic diag_status_route,
    // interrupt outputs
    output logic [15:0] isa_irq,
    output logic system_mgmt_irq,
    output logic [1:0] pci_irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr, input int sock, input logic [7:0] offset);
        logic [7:0] base;
        base = (sock == 0) ? status_irq_pkg::SOCKET_A_BASE : status_irq_pkg::SOCKET_B_BASE;
        reg_hit = (addr == (base | offset));
    endfunction : reg_hit

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic [9:0] lines_sync;
    status_irq_pkg::card_lines_t [1:0] lines_now;

    input_sync3 #(
        .WIDTH(10)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .din(card_lines),
        .dout(lines_sync)
    );

    assign lines_now = lines_sync;

    // ------------------------------------------------------------
    // per-socket state
    // ------------------------------------------------------------
    status_irq_pkg::card_lines_t [1:0] lines_prev_reg;
    status_irq_pkg::card_lines_t [1:0] lines_prev_next;
    logic [3:0] flag_reg [2];
    logic [3:0] flag_next [2];
    logic [7:0] config_reg [2];
    logic [7:0] config_next [2];
    logic [3:0] event_set [2];
    logic [3:0] flag_clear [2];
    logic [3:0] kind_mask [2];

    always_comb begin
        lines_prev_next = lines_now;
        for (int s = 0; s < status_irq_pkg::SOCKETS; s++) begin
            // raw events, before masking
            event_set[s] = '0;
            event_set[s][status_irq_pkg::FLAG_DETECT] =
                (lines_now[s].card_detect_a_n ^ lines_prev_reg[s].card_detect_a_n) |
                (lines_now[s].card_detect_b_n ^ lines_prev_reg[s].card_detect_b_n);
            event_set[s][status_irq_pkg::FLAG_READY] =
                lines_now[s].ready & ~lines_prev_reg[s].ready;
            event_set[s][status_irq_pkg::FLAG_WARN] = lines_now[s].battery_warn;
            event_set[s][status_irq_pkg::FLAG_DEAD] = lines_now[s].card_status_line;
            // mask sources by enable bits
            event_set[s] = event_set[s] & config_reg[s][3:0];
            kind_mask[s] = socket_ctl[s].card_kind ?
                status_irq_pkg::IO_CARD_FLAG_MASK : status_irq_pkg::MEM_CARD_FLAG_MASK;
            // clear on read or on write of one
            flag_clear[s] = '0;
            if (!clear_mode_w1c && reg_req.rd && reg_hit(reg_req.addr, s, status_irq_pkg::STATUS_OFFSET)) begin
                flag_clear[s] = 4'hF;
            end
            if (clear_mode_w1c && reg_req.wr && reg_hit(reg_req.addr, s, status_irq_pkg::STATUS_OFFSET)) begin
                flag_clear[s] = reg_req.wdata[3:0];
            end
            // a new event beats a clear in the same cycle
            flag_next[s] = ((flag_reg[s] & ~flag_clear[s]) | event_set[s]) & config_reg[s][3:0] & kind_mask[s];
            if (socket_ctl[s].ring_indicate_enable) begin
                flag_next[s][status_irq_pkg::FLAG_DEAD] =
                    lines_now[s].card_status_line & config_reg[s][status_irq_pkg::FLAG_DEAD];
            end
            config_next[s] = config_reg[s];
            if (reg_req.wr && reg_hit(reg_req.addr, s, status_irq_pkg::CONFIG_OFFSET)) begin
                config_next[s] = reg_req.wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lines_prev_reg <= {status_irq_pkg::LINES_RESET, status_irq_pkg::LINES_RESET};
            for (int s = 0; s < status_irq_pkg::SOCKETS; s++) begin
                flag_reg[s] <= status_irq_pkg::STATUS_RESET[3:0];
                config_reg[s] <= status_irq_pkg::CONFIG_RESET;
            end
        end else begin
            lines_prev_reg <= lines_prev_next;
            for (int s = 0; s < status_irq_pkg::SOCKETS; s++) begin
                flag_reg[s] <= flag_next[s];
                config_reg[s] <= config_next[s];
            end
        end
    end

    // ------------------------------------------------------------
    // register read data
    // ------------------------------------------------------------
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = rdata_reg;
        if (reg_req.rd) begin
            rdata_next = 8'h00;
            for (int s = 0; s < status_irq_pkg::SOCKETS; s++) begin
                if (reg_hit(reg_req.addr, s, status_irq_pkg::STATUS_OFFSET)) begin
                    rdata_next = {4'h0, flag_reg[s] & config_reg[s][3:0] & kind_mask[s]};
                end
                if (reg_hit(reg_req.addr, s, status_irq_pkg::CONFIG_OFFSET)) begin
                    rdata_next = config_reg[s];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ------------------------------------------------------------
    // interrupt routing
    // ------------------------------------------------------------
    logic [15:0] isa_reg;
    logic [15:0] isa_next;
    logic mgmt_reg;
    logic mgmt_next;
    logic [1:0] pci_reg;
    logic [1:0] pci_next;
    logic [1:0] pending;
    logic [3:0] select [2];

    always_comb begin
        isa_next = '0;
        mgmt_next = 1'b0;
        pci_next = '0;
        for (int s = 0; s < status_irq_pkg::SOCKETS; s++) begin
            pending[s] = |flag_reg[s];
            select[s] = config_reg[s][status_irq_pkg::SELECT_LSB +: 4];
            if (socket_ctl[s].status_to_pci_route) begin
                pci_next[s] = pending[s];
            end else if (select[s] == status_irq_pkg::SELECT_NONE) begin
                pci_next[s] = pending[s] & diag_status_route;
            end else if (select[s] == status_irq_pkg::SELECT_MGMT) begin
                mgmt_next = mgmt_next | pending[s];
            end else begin
                isa_next[select[s]] = isa_next[select[s]] | pending[s];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            isa_reg <= '0;
            mgmt_reg <= 1'b0;
            pci_reg <= '0;
        end else begin
            isa_reg <= isa_next;
            mgmt_reg <= mgmt_next;
            pci_reg <= pci_next;
        end
    end

    assign isa_irq = isa_reg;
    assign system_mgmt_irq = mgmt_reg;
    assign pci_irq = pci_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    reserved_bits_zero_a: assert property (
        reg_req.rd && (reg_hit(reg_req.addr, 0, status_irq_pkg::STATUS_OFFSET) ||
            reg_hit(reg_req.addr, 1, status_irq_pkg::STATUS_OFFSET)) |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved status bits read nonzero");

    sequence no_pending_s;
        pending == 2'b00;
    endsequence

    quiet_outputs_a: assert property (
        no_pending_s |=> isa_irq == 16'h0000 && !system_mgmt_irq && pci_irq == 2'b00)
        else $error("interrupt raised with no flag set");

    isa_low_unused_a: assert property (
        isa_irq[0] == 1'b0 && isa_irq[2] == 1'b0)
        else $error("unused interrupt line raised");

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chk
            sequence status_read_s;
                reg_req.rd && !clear_mode_w1c && reg_hit(reg_req.addr, g, status_irq_pkg::STATUS_OFFSET);
            endsequence
            sequence quiet_s;
                !socket_ctl[g].ring_indicate_enable;
            endsequence
            sequence ring_on_s;
                socket_ctl[g].ring_indicate_enable && config_reg[g][status_irq_pkg::FLAG_DEAD];
            endsequence
            sequence memory_card_s;
                !socket_ctl[g].card_kind;
            endsequence
            sequence status_write_s;
                reg_req.wr && clear_mode_w1c && reg_hit(reg_req.addr, g, status_irq_pkg::STATUS_OFFSET);
            endsequence
            sequence config_write_s;
                reg_req.wr && reg_hit(reg_req.addr, g, status_irq_pkg::CONFIG_OFFSET);
            endsequence

            masked_flag_zero_a: assert property (
                (flag_reg[g] & ~config_reg[g][3:0]) == 4'h0 || $changed(config_reg[g]))
                else $error("masked flag is set");
            io_card_zero_a: assert property (
                socket_ctl[g].card_kind && $stable(socket_ctl[g].card_kind) |-> flag_reg[g][2:1] == 2'b00)
                else $error("io card shows ready or warning flag");
            detect_sets_flag_a: assert property (
                event_set[g][status_irq_pkg::FLAG_DETECT] && $stable(config_reg[g]) |=> flag_reg[g][3])
                else $error("card detect change not latched");
            ready_rise_a: assert property (
                $rose(flag_reg[g][2]) |-> $past(event_set[g][status_irq_pkg::FLAG_READY]))
                else $error("ready flag set without rising edge");
            flag_held_a: assert property (
                flag_reg[g][3] && flag_clear[g][3] == 1'b0 && config_reg[g][3] && config_next[g][3] |=> flag_reg[g][3])
                else $error("detect flag dropped without clear");
            read_clears_a: assert property (
                status_read_s ##0 (event_set[g] == 4'h0) ##0 quiet_s |=> flag_reg[g] == 4'h0)
                else $error("clear on read failed");
            pci_route_a: assert property (
                pending[g] && socket_ctl[g].status_to_pci_route |=> pci_irq[g])
                else $error("pci route not taken");
            isa_route_a: assert property (
                pending[g] && !socket_ctl[g].status_to_pci_route && select[g] > 4'h2 |=> isa_irq[$past(select[g])])
                else $error("isa route not taken");
            diag_route_a: assert property (
                pending[g] && select[g] == 4'h0 && diag_status_route |=> pci_irq[g])
                else $error("diagnostic route not taken");

            ring_follows_line_a: assert property (
                ring_on_s |=> flag_reg[g][0] == $past(lines_now[g].card_status_line))
                else $error("ring flag does not follow line");
            warn_sets_flag_a: assert property (
                memory_card_s ##0 (lines_now[g].battery_warn && config_reg[g][1]) |=> flag_reg[g][1])
                else $error("battery warning not latched");
            dead_sets_flag_a: assert property (
                quiet_s ##0 (lines_now[g].card_status_line && config_reg[g][0]) |=> flag_reg[g][0])
                else $error("status line not latched");
            write_one_clears_a: assert property (
                status_write_s ##0 (reg_req.wdata[3] && !event_set[g][3]) |=> !flag_reg[g][3])
                else $error("write of one did not clear");
            set_beats_clear_a: assert property (
                status_write_s ##0 event_set[g][3] |=> flag_reg[g][3])
                else $error("clear won over new event");
            config_write_a: assert property (
                config_write_s |=> config_reg[g] == $past(reg_req.wdata))
                else $error("config write lost");
            mgmt_route_a: assert property (
                pending[g] && !socket_ctl[g].status_to_pci_route && select[g] == 4'h2 |=> system_mgmt_irq)
                else $error("management route not taken");
            no_pci_route_a: assert property (
                !socket_ctl[g].status_to_pci_route && select[g] == 4'h0 && !diag_status_route |=> !pci_irq[g])
                else $error("pci raised with no route");
            detect_masked_a: assert property (
                !config_reg[g][3] |=> !flag_reg[g][3])
                else $error("masked detect flag set");
            ready_masked_a: assert property (
                !config_reg[g][2] |=> !flag_reg[g][2])
                else $error("masked ready flag set");
            warn_masked_a: assert property (
                !config_reg[g][1] |=> !flag_reg[g][1])
                else $error("masked warning flag set");
        end
    endgenerate

endmodule : status_change_irq

`default_nettype wire

// File: test/card_pins_model.sv
// card-side model of the detect, ready, battery and status pins of both sockets
`default_nettype none

module card_pins_model (
    // card pins
    output var status_irq_pkg::card_lines_t [1:0] lines
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------
    initial lines = status_irq_pkg::LINES_RESET;

    // pins move with no relation to the host clock, after a short or long card delay
    task automatic apply(input int s, input status_irq_pkg::card_lines_t v, input int dly_ns);
        #(dly_ns);
        lines[s] = v;
    endtask : apply
endmodule : card_pins_model

`default_nettype wire

// File: test/status_change_irq_tb_top.sv
// self-checking bench for the card status-change interrupt block
`default_nettype none

module status_change_irq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] ST_A = status_irq_pkg::SOCKET_A_BASE + status_irq_pkg::STATUS_OFFSET;
    localparam logic [7:0] CF_A = status_irq_pkg::SOCKET_A_BASE + status_irq_pkg::CONFIG_OFFSET;
    localparam logic [7:0] CF_B = status_irq_pkg::SOCKET_B_BASE + status_irq_pkg::CONFIG_OFFSET;
    localparam logic [7:0] ST_B = status_irq_pkg::SOCKET_B_BASE + status_irq_pkg::STATUS_OFFSET;
    logic clk;
    logic rstn;
    status_irq_pkg::reg_req_t reg_req;
    logic [7:0] reg_rdata;
    status_irq_pkg::card_lines_t [1:0] card_lines;
    status_irq_pkg::socket_ctl_t [1:0] socket_ctl;
    logic clear_mode_w1c;
    logic diag_status_route;
    logic [15:0] isa_irq;
    logic system_mgmt_irq;
    logic [1:0] pci_irq;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 32'hA850;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] rnd;
    logic [15:0] e_isa;
    status_irq_pkg::card_lines_t ln;

    card_pins_model card (.lines(card_lines));
    status_change_irq uut (.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .card_lines(card_lines), .socket_ctl(socket_ctl), .clear_mode_w1c(clear_mode_w1c),
        .diag_status_route(diag_status_route), .isa_irq(isa_irq), .system_mgmt_irq(system_mgmt_irq),
        .pci_irq(pci_irq));

    // ------------------------------------------------------------
    // clock, timeout, read monitor
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        rd_seen <= reg_req.rd;
        if (cycles == 5000) begin
            num_errors++;
            print_verdict();
        end
    end

    always @(negedge clk) begin
        if (rd_seen) begin
            cmp_read(exp_q.pop_front(), reg_rdata);
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_read(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("Error reg_rdata expected %h seen %h", e, g);
        end
    endtask : cmp_read

    task automatic cmp_irq(input logic [18:0] e, input logic [18:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("Error isa_mgmt_pci expected %h seen %h", e, g);
        end
    endtask : cmp_irq

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk);
        reg_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        exp_q.push_back(e);
        reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clk);
        reg_req.rd <= 1'b0;
    endtask : rd

    task automatic irq(input logic [15:0] isa, input logic mg, input logic [1:0] pci);
        repeat (2) @(negedge clk);
        cmp_irq({isa, mg, pci}, {isa_irq, system_mgmt_irq, pci_irq});
    endtask : irq

    // change one pin of socket s, then wait past synchroniser and flag
    task automatic pin(input int s, input int f, input logic v, input int dly);
        ln = card_lines[s];
        ln[f] = v;
        card.apply(s, ln, dly);
        repeat (8) @(negedge clk);
    endtask : pin

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        reg_req = '0;
        socket_ctl = '0;
        clear_mode_w1c = 1'b0;
        diag_status_route = 1'b0;
        rstn = 1'b0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        rd(ST_A, 8'h00);
        rd(CF_A, 8'h00);
        rd(8'h07, 8'h00);
        wr(CF_A, 8'h34);
        rd(CF_A, 8'h34);
        pin(0, 2, 1'b1, 1);
        irq(16'h0008, 1'b0, 2'b00);
        rd(ST_A, 8'h04);
        rd(ST_A, 8'h00);
        irq(16'h0000, 1'b0, 2'b00);
        pin(0, 2, 1'b0, 37);
        rd(ST_A, 8'h00);
        pin(0, 4, 1'b1, 3);
        rd(ST_A, 8'h00);
        clear_mode_w1c = 1'b1;
        wr(CF_A, 8'h39);
        pin(0, 3, 1'b1, 1);
        rd(ST_A, 8'h08);
        rd(ST_A, 8'h08);
        wr(ST_A, 8'h08);
        rd(ST_A, 8'h00);
        pin(0, 0, 1'b1, 1);
        rd(ST_A, 8'h01);
        pin(0, 0, 1'b0, 1);
        wr(ST_A, 8'h01);
        rd(ST_A, 8'h00);
        socket_ctl[0].card_kind = 1'b1;
        wr(CF_A, 8'h37);
        pin(0, 1, 1'b1, 1);
        pin(0, 2, 1'b1, 1);
        rd(ST_A, 8'h00);
        pin(0, 0, 1'b1, 1);
        rd(ST_A, 8'h01);
        irq(16'h0008, 1'b0, 2'b00);
        pin(0, 0, 1'b0, 1);
        pin(0, 2, 1'b0, 1);
        pin(0, 1, 1'b0, 1);
        wr(ST_A, 8'h01);
        socket_ctl[0].card_kind = 1'b0;
        socket_ctl[0].ring_indicate_enable = 1'b1;
        wr(CF_A, 8'h31);
        pin(0, 0, 1'b1, 1);
        rd(ST_A, 8'h01);
        pin(0, 0, 1'b0, 1);
        rd(ST_A, 8'h00);
        socket_ctl[0].ring_indicate_enable = 1'b0;
        pin(0, 1, 1'b1, 1);
        for (int r = 0; r < 4; r++) begin
            socket_ctl[0].status_to_pci_route = r[1];
            diag_status_route = r[0];
            for (int sel = 0; sel < 16; sel++) begin
                wr(CF_A, {4'(sel), 4'h2});
                e_isa = '0;
                if (r[1] == 1'b1 || (sel == 0 && r[0] == 1'b1)) begin
                    irq(16'h0000, 1'b0, 2'b01);
                end else if (sel == 2) begin
                    irq(16'h0000, 1'b1, 2'b00);
                end else begin
                    if (sel != 0) begin
                        e_isa[sel] = 1'b1;
                    end
                    irq(e_isa, 1'b0, 2'b00);
                end
            end
        end
        wr(CF_A, 8'h00);
        rd(ST_A, 8'h00);
        pin(0, 1, 1'b0, 1);
        clear_mode_w1c = 1'b0;
        repeat (4) begin
            rnd = 8'($random(seed));
            wr(CF_B, rnd);
            rd(CF_B, rnd);
            wr(ST_A, rnd);
            rd(ST_A, 8'h00);
        end
        wr(CF_B, 8'h08);
        pin(1, 4, 1'b1, 1);
        irq(16'h0000, 1'b0, 2'b10);
        rd(ST_B, 8'h08);
        rd(ST_B, 8'h00);
        rd(CF_A, 8'h00);
        print_verdict();
    end
endmodule : status_change_irq_tb_top

`default_nettype wire
